// >>> logic/dsa_alu.sv
// DSP ALU: fixed-point, integer and logical operations on the DSP
// register file, with condition flags, in the final pipeline stage.
// Assumes the core issues decoded requests on the same clock.
//
// What this block does
// RQ1: Fixed-point is 40-bit, guards sign-extended, truncated
// RQ2: Results written in DSP stage, any registers
// RQ3: Same-line load: ALU reads old value first
// RQ4: Sum, diff, carry forms, compare, copy, abs, negate, clear
// RQ5: Only unconditional operations update all five flags
// RQ6: Select 000: carry or borrow from bit 31
// RQ7: Select 001: sign of full 40-bit result
// RQ8: Select 010: result equals zero
// RQ9: Select 011: result beyond base 32-bit range
// RQ10: Select 100: not((negative xor over-range) or zero)
// RQ11: Select 101: signed source 1 at least source 2
// RQ12: Side flags mirror negative, zero, overflow, greater modes
// RQ13: Carry forms always load carry or borrow
// RQ14: Limit flag saturates all arithmetic operations
// RQ15: Integer is 24-bit upper word, low word cleared
// RQ16: Increment and decrement by constant one only
// RQ17: Integer flags ignore the low words
// RQ18: Logical uses upper word, rest cleared
// RQ19: Logical AND, OR, XOR of two registers
// RQ20: Conditional logical operations leave flags alone
// RQ21: Logical, select 001: cond takes result bit 31
// RQ22: Logical, select 010: cond set on all zeros
// RQ23: Logical, other selects: cond cleared
// RQ24: Condition gates only DSP register writes
// RQ25: Abs magnitude, negate two's complement, copy unchanged
// RQ26: Software compares before greater-type conditional use
module dsa_alu #(
  parameter int REGS = dsa_pkg::REG_CNT    // Register count
) (
  input  wire logic                     clock,       // Core clock
  input  wire logic                     rst_n,       // Async reset
  input  wire dsa_pkg::dsa_req_t        aluReq,      // ALU request
  input  wire dsa_pkg::dsa_load_t       loadReq,     // Memory load
  input  wire logic [2:0]               condSelect,  // Condition mode
  input  wire logic                     limitOnFlag, // Saturation on
  input  wire logic [dsa_pkg::IDX_W-1:0] readIdx,    // Readback index
  output logic [dsa_pkg::FULL_W-1:0]    readData_ff, // Readback value
  output dsa_pkg::dsa_flags_t           flags_ff,    // Condition flags
  output logic                          done_ff,     // Op retired
  output logic [dsa_pkg::FULL_W-1:0]    result_ff    // Last result
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration check
  initial begin
    if (REGS != dsa_pkg::REG_CNT) begin
      $error("dsa_alu: register count must be 8");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic [dsa_pkg::FULL_W-1:0] regs_ff [REGS];   // Data registers
  logic [dsa_pkg::FULL_W-1:0] nxt_wrData;       // ALU write value
  logic                       nxt_wrEn;         // ALU write enable

  // Registers without guards read as sign-extended base words
  function automatic logic [dsa_pkg::FULL_W-1:0] rd(
    input logic [dsa_pkg::IDX_W-1:0] idx,
    input logic [dsa_pkg::FULL_W-1:0] v
  );
    if (idx < dsa_pkg::GUARD_REGS) begin
      rd = v;
    end else begin
      rd = {{dsa_pkg::GUARD_W{v[dsa_pkg::BASE_MSB]}},
            v[dsa_pkg::BASE_W-1:0]};
    end
  endfunction

  // One flop bank per register; load lands after the ALU write
  for (genvar g = 0; g < REGS; g++) begin : gReg
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        regs_ff[g] <= dsa_pkg::REG_RST;
      end else if (loadReq.valid && loadReq.idx == g) begin
        regs_ff[g] <= loadReq.data;                          // RQ3
      end else if (nxt_wrEn && aluReq.dst == g) begin
        regs_ff[g] <= nxt_wrData;                            // RQ2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operand fetch; old register values, so a same-line load is unseen
  logic [dsa_pkg::FULL_W-1:0] opX;      // Source 1, 40-bit view
  logic [dsa_pkg::FULL_W-1:0] opY;      // Source 2, 40-bit view
  logic [dsa_pkg::FULL_W-1:0] upX;      // Source 1 upper-word view
  logic [dsa_pkg::FULL_W-1:0] upY;      // Source 2 upper-word view

  always_comb begin
    opX = rd(aluReq.srcX, regs_ff[aluReq.srcX]);             // RQ1 RQ3
    opY = rd(aluReq.srcY, regs_ff[aluReq.srcY]);             // RQ1
    upX = {opX[dsa_pkg::FULL_W-1:dsa_pkg::WORD_LSB],
           16'h0000};                                        // RQ15
    upY = {opY[dsa_pkg::FULL_W-1:dsa_pkg::WORD_LSB], 16'h0000};
  end

  ////////////////////////////////////////////////////////////////////////
  // Adder inputs: one adder serves every arithmetic operation
  logic [dsa_pkg::FULL_W-1:0] addA;     // Left addend
  logic [dsa_pkg::FULL_W-1:0] addB;     // Right addend, maybe inverted
  logic                       cin;      // Carry in
  logic                       isSub;    // Subtract form
  logic                       isArith;  // Arithmetic, not logical
  logic                       isInt;    // Integer form

  always_comb begin
    addA    = opX;
    addB    = opY;
    cin     = 1'b0;
    isSub   = 1'b0;
    isArith = 1'b1;
    isInt   = 1'b0;
    case (aluReq.op)
      dsa_pkg::SUM_OP: begin
      end
      dsa_pkg::DIFF_OP, dsa_pkg::COMPARE_OP: begin           // RQ4
        addB  = ~opY;
        cin   = 1'b1;
        isSub = 1'b1;
      end
      dsa_pkg::SUM_CARRY_OP: begin
        cin = flags_ff.cond;                                 // RQ4
      end
      dsa_pkg::DIFF_BORROW_OP: begin
        addB  = ~opY;
        cin   = ~flags_ff.cond;
        isSub = 1'b1;
      end
      dsa_pkg::COPY_OP: begin                                // RQ25
        addA = aluReq.useY ? opY : opX;
        addB = '0;
      end
      dsa_pkg::ABSOLUTE_OP, dsa_pkg::NEGATE_OP: begin        // RQ25
        addA  = '0;
        addB  = ~(aluReq.useY ? opY : opX);
        cin   = 1'b1;
        isSub = 1'b1;
        // A non-negative source is passed through unchanged
        if (aluReq.op == dsa_pkg::ABSOLUTE_OP &&
            addB[dsa_pkg::SIGN_BIT]) begin
          addA  = aluReq.useY ? opY : opX;
          addB  = '0;
          cin   = 1'b0;
          isSub = 1'b0;
        end
      end
      dsa_pkg::CLEAR_OP: begin                               // RQ4
        addA = '0;
        addB = '0;
      end
      dsa_pkg::INCREMENT_OP: begin                           // RQ16
        addA  = aluReq.useY ? upY : upX;
        addB  = dsa_pkg::INT_ONE;
        isInt = 1'b1;
      end
      dsa_pkg::DECREMENT_OP: begin                           // RQ16
        addA  = aluReq.useY ? upY : upX;
        addB  = ~dsa_pkg::INT_ONE;
        cin   = 1'b1;
        isSub = 1'b1;
        isInt = 1'b1;
      end
      default: begin
        isArith = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sum, carries and logical result
  logic [dsa_pkg::FULL_W:0]   wide;     // 41-bit true sum
  logic [dsa_pkg::BASE_W:0]   lowSum;   // Base part with carry out
  logic [dsa_pkg::WORD_W-1:0] logRes;   // Logical upper word
  logic                       carry31;  // Carry or borrow from bit 31

  always_comb begin
    wide    = {addA[dsa_pkg::SIGN_BIT], addA} +
              {addB[dsa_pkg::SIGN_BIT], addB} +
              {{dsa_pkg::FULL_W{1'b0}}, cin};                // RQ1
    lowSum  = {1'b0, addA[dsa_pkg::BASE_W-1:0]} +
              {1'b0, addB[dsa_pkg::BASE_W-1:0]} +
              {{dsa_pkg::BASE_W{1'b0}}, cin};
    carry31 = lowSum[dsa_pkg::BASE_W] ^ isSub;               // RQ6
    case (aluReq.op)                                         // RQ18
      dsa_pkg::AND_OP: logRes = opX[31:16] & opY[31:16];     // RQ19
      dsa_pkg::OR_OP:  logRes = opX[31:16] | opY[31:16];
      dsa_pkg::XOR_OP: logRes = opX[31:16] ^ opY[31:16];
      default:         logRes = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag terms; over-range uses the full 40-bit width
  logic                       rawNeg;   // Sign of 40-bit result
  logic                       rawZero;  // Result equals zero
  logic                       rawOvf;   // Beyond base 32-bit range
  logic                       overRng;  // Beyond 40-bit range
  logic                       rawGt;    // Signed greater than
  logic                       rawGe;    // Signed greater or equal
  logic [dsa_pkg::FULL_W-1:0] arithRes; // Saturated 40-bit result
  logic                       dstGuard; // Destination holds guards
  dsa_pkg::dsa_flags_t        nxt_flags;

  always_comb begin
    dstGuard = aluReq.dst < dsa_pkg::GUARD_REGS;
    rawNeg   = wide[dsa_pkg::SIGN_BIT];                      // RQ7
    rawZero  = wide[dsa_pkg::FULL_W-1:0] == '0;              // RQ8 RQ17
    rawOvf   = wide[dsa_pkg::SIGN_BIT:dsa_pkg::BASE_MSB] != '0 &&
               wide[dsa_pkg::SIGN_BIT:dsa_pkg::BASE_MSB] != '1; // RQ9
    overRng  = wide[dsa_pkg::FULL_W] ^ wide[dsa_pkg::SIGN_BIT];
    rawGt    = ~((rawNeg ^ overRng) | rawZero);              // RQ10
    rawGe    = ~(rawNeg ^ overRng);                          // RQ11
    arithRes = wide[dsa_pkg::FULL_W-1:0];
    // Saturate to the destination's own range
    if (limitOnFlag && dstGuard && overRng) begin            // RQ14
      arithRes = wide[dsa_pkg::FULL_W] ? 40'h80_0000_0000
                                       : 40'h7F_FFFF_FFFF;
    end else if (limitOnFlag && !dstGuard &&
                 (rawOvf || overRng)) begin                  // RQ14
      arithRes = wide[dsa_pkg::FULL_W] ? 40'hFF_8000_0000
                                       : 40'h00_7FFF_FFFF;
    end
    if (isInt) begin
      arithRes[dsa_pkg::WORD_LSB-1:0] = '0;                  // RQ15
    end
    // Condition select
    nxt_flags = '0;
    if (isArith) begin
      nxt_flags.msb     = rawNeg;                            // RQ12
      nxt_flags.zero    = rawZero;
      nxt_flags.ovf     = rawOvf;
      nxt_flags.greater = rawGt;
      case (condSelect)
        dsa_pkg::CS_CARRY: nxt_flags.cond = carry31;         // RQ6
        dsa_pkg::CS_NEG:   nxt_flags.cond = rawNeg;          // RQ7
        dsa_pkg::CS_ZERO:  nxt_flags.cond = rawZero;         // RQ8
        dsa_pkg::CS_OVF:   nxt_flags.cond = rawOvf;          // RQ9
        dsa_pkg::CS_GT:    nxt_flags.cond = rawGt;           // RQ10
        dsa_pkg::CS_GE:    nxt_flags.cond = rawGe;           // RQ11
        default:           nxt_flags.cond = 1'b0;
      endcase
      if (aluReq.op == dsa_pkg::SUM_CARRY_OP ||
          aluReq.op == dsa_pkg::DIFF_BORROW_OP) begin
        nxt_flags.cond = carry31;                            // RQ13
      end
    end else begin
      nxt_flags.msb  = logRes[dsa_pkg::WORD_W-1];            // RQ21
      nxt_flags.zero = logRes == '0;                         // RQ22
      case (condSelect)
        dsa_pkg::CS_NEG:  nxt_flags.cond = nxt_flags.msb;    // RQ21
        dsa_pkg::CS_ZERO: nxt_flags.cond = nxt_flags.zero;   // RQ22
        default:          nxt_flags.cond = 1'b0;             // RQ23
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Execution gate; it touches only the DSP register write
  logic execOk;                         // Condition allows the op
  logic flagUpd;                        // Flags take the new values

  always_comb begin
    case (aluReq.exec)
      dsa_pkg::EXEC_ALWAYS:   execOk = 1'b1;
      dsa_pkg::EXEC_IF_SET:   execOk = flags_ff.cond;        // RQ24
      dsa_pkg::EXEC_IF_CLEAR: execOk = ~flags_ff.cond;       // RQ24
      default:                execOk = 1'b0;
    endcase
    flagUpd  = aluReq.valid &&
               aluReq.exec == dsa_pkg::EXEC_ALWAYS;          // RQ5 RQ20
    nxt_wrEn = aluReq.valid && execOk &&
               aluReq.op != dsa_pkg::COMPARE_OP;             // RQ4
    if (isArith) begin
      nxt_wrData = arithRes;                                 // RQ1
    end else begin
      nxt_wrData = {8'h00, logRes, 16'h0000};                // RQ18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags; a conditional op leaves them as they were
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= '{default: dsa_pkg::FLAG_RST};
    end else if (flagUpd) begin
      flags_ff <= nxt_flags;                                 // RQ5 RQ12
    end
  end

  // Retire strobe and result, for the pipeline's bypass and trace
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_ff   <= 1'b0;
      result_ff <= dsa_pkg::REG_RST;
    end else begin
      done_ff <= nxt_wrEn;
      if (nxt_wrEn) begin
        result_ff <= nxt_wrData;
      end
    end
  end

  // Registered readback of any register in its 40-bit view
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readData_ff <= dsa_pkg::REG_RST;
    end else begin
      readData_ff <= rd(readIdx, regs_ff[readIdx]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_condIssue;
    aluReq.valid && aluReq.exec != dsa_pkg::EXEC_ALWAYS;
  endsequence

  property p_condKeepsFlags;
    @(posedge clock) disable iff (!rst_n)
      s_condIssue |=> $stable(flags_ff);
  endproperty
  a_condKeepsFlags: assert property (p_condKeepsFlags) // RQ5
    else $error("conditional op changed flags");

  property p_clearZero;
    @(posedge clock) disable iff (!rst_n)
      aluReq.valid && aluReq.exec == dsa_pkg::EXEC_ALWAYS &&
      aluReq.op == dsa_pkg::CLEAR_OP
      |=> flags_ff.zero && !flags_ff.msb && regs_ff[$past(aluReq.dst)] == '0
        || $past(loadReq.valid);
  endproperty
  a_clearZero: assert property (p_clearZero) // RQ4
    else $error("clear did not give zero");

  property p_compareNoWrite;
    @(posedge clock) disable iff (!rst_n)
      aluReq.valid && aluReq.op == dsa_pkg::COMPARE_OP
      && !loadReq.valid
      |=> regs_ff[$past(aluReq.dst)] == $past(regs_ff[aluReq.dst]);
  endproperty
  a_compareNoWrite: assert property (p_compareNoWrite) // RQ4
    else $error("compare wrote a register");

  property p_logicClears;
    @(posedge clock) disable iff (!rst_n)
      done_ff && $past(!isArith)
      |-> result_ff[15:0] == '0 && result_ff[39:32] == '0;
  endproperty
  a_logicClears: assert property (p_logicClears) // RQ18
    else $error("logical result not cleared outside upper word");

  property p_intLowClear;
    @(posedge clock) disable iff (!rst_n)
      done_ff && $past(isInt) |-> result_ff[15:0] == '0;
  endproperty
  a_intLowClear: assert property (p_intLowClear) // RQ15
    else $error("integer result low word not cleared");

  property p_logicCondCleared;
    @(posedge clock) disable iff (!rst_n)
      aluReq.valid && aluReq.exec == dsa_pkg::EXEC_ALWAYS && !isArith &&
      condSelect inside {3'h0, 3'h3, 3'h4, 3'h5}
      |=> !flags_ff.cond && !flags_ff.ovf && !flags_ff.greater;
  endproperty
  a_logicCondCleared: assert property (p_logicCondCleared) // RQ23
    else $error("logical op left a cleared flag set");

  property p_negMirror;
    @(posedge clock) disable iff (!rst_n)
      flagUpd && condSelect == dsa_pkg::CS_NEG &&
      aluReq.op != dsa_pkg::SUM_CARRY_OP &&
      aluReq.op != dsa_pkg::DIFF_BORROW_OP
      |=> flags_ff.cond == flags_ff.msb;
  endproperty
  a_negMirror: assert property (p_negMirror) // RQ12
    else $error("negative flag differs from cond in negative mode");

  property p_gtImpliesGe;
    @(posedge clock) disable iff (!rst_n)
      flagUpd && isArith && condSelect == dsa_pkg::CS_GE
      |=> !flags_ff.greater || flags_ff.cond;
  endproperty
  a_gtImpliesGe: assert property (p_gtImpliesGe) // RQ11
    else $error("greater set but greater-or-equal clear");

  property p_satBase;
    @(posedge clock) disable iff (!rst_n)
      nxt_wrEn && isArith && limitOnFlag && !dstGuard
      |=> result_ff[39:31] == '0 || result_ff[39:31] == '1;
  endproperty
  a_satBase: assert property (p_satBase) // RQ14
    else $error("saturated result left base range");

endmodule

// >>> logic/dsa_pkg.sv
// Shared types and constants of the DSP ALU datapath.
// Assumes one core clock; operands arrive already decoded.
package dsa_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths and register layout
  localparam int FULL_W     = 40;        // Base plus guard bits
  localparam int BASE_W     = 32;        // Base precision
  localparam int GUARD_W    = 8;         // Guard bits
  localparam int WORD_W     = 16;        // Upper word
  localparam int WORD_LSB   = 16;        // Position of upper word
  localparam int SIGN_BIT   = 39;        // Full result sign
  localparam int BASE_MSB   = 31;        // Top of base precision
  localparam int REG_CNT    = 8;         // DSP data registers
  localparam int GUARD_REGS = 2;         // Registers 0..1 hold guards
  localparam int IDX_W      = 3;         // Register index width

  ////////////////////////////////////////////////////////////////////////
  // Condition select codes
  localparam logic [2:0] CS_CARRY = 3'h0; // Carry or borrow, default
  localparam logic [2:0] CS_NEG   = 3'h1; // Negative
  localparam logic [2:0] CS_ZERO  = 3'h2; // Zero
  localparam logic [2:0] CS_OVF   = 3'h3; // Overflow
  localparam logic [2:0] CS_GT    = 3'h4; // Signed greater than
  localparam logic [2:0] CS_GE    = 3'h5; // Signed greater or equal

  // Reset values
  localparam logic [FULL_W-1:0] REG_RST  = 40'h00_0000_0000;
  localparam logic              FLAG_RST = 1'h0;
  // Integer step of one in the upper word
  localparam logic [FULL_W-1:0] INT_ONE  = 40'h00_0001_0000;

  ////////////////////////////////////////////////////////////////////////
  // Operations and execution conditions
  typedef enum logic [3:0] {
    SUM_OP, DIFF_OP, SUM_CARRY_OP, DIFF_BORROW_OP, COMPARE_OP,
    COPY_OP, ABSOLUTE_OP, NEGATE_OP, CLEAR_OP,
    INCREMENT_OP, DECREMENT_OP, AND_OP, OR_OP, XOR_OP
  } dsa_op_t;

  typedef enum logic [1:0] {
    EXEC_ALWAYS, EXEC_IF_SET, EXEC_IF_CLEAR
  } dsa_exec_t;

  typedef struct packed {
    logic             valid;   // One-cycle issue strobe
    dsa_op_t          op;      // Operation
    dsa_exec_t        exec;    // Unconditional or conditional
    logic [IDX_W-1:0] srcX;    // Source 1 index
    logic [IDX_W-1:0] srcY;    // Source 2 index
    logic [IDX_W-1:0] dst;     // Destination index
    logic             useY;    // One-source ops take srcY instead of srcX
  } dsa_req_t;

  typedef struct packed {
    logic              valid;  // Load write strobe
    logic [IDX_W-1:0]  idx;    // Target register
    logic [FULL_W-1:0] data;   // Value, already formatted
  } dsa_load_t;

  typedef struct packed {
    logic cond;     // Selected condition
    logic msb;      // Negative
    logic zero;     // Zero
    logic ovf;      // Overflow
    logic greater;  // Signed greater than
  } dsa_flags_t;

endpackage

// >>> tb/dsa_core_model.sv
// Core-side partner: issues memory loads into the DSP registers.
// Assumes one core clock; loads change just after a rising edge.
module dsa_core_model (
  input  wire logic         clock,   // Core clock
  output dsa_pkg::dsa_load_t loadReq // Load to register file
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////
  // Idle: no strobe, data driven to a junk pattern
  initial begin
    loadReq = '{1'b0, 3'h0, 40'hA5_A5A5_A5A5};
  end

  // One-cycle load pulse; data inverted after release so stale
  // values are never mistaken for a live load
  task automatic load(input logic [2:0] idx, input logic [39:0] d);
    @(posedge clock);
    #1;
    loadReq = '{1'b1, idx, d};
    @(posedge clock);
    #1;
    loadReq.valid = 1'b0;
    loadReq.data  = ~d;
  endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench of the DSP ALU with its condition flags.
// Assumes the core model drives loads; saturation is tried once.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clock;      // Core clock
  logic                rst_n;      // Async reset
  dsa_pkg::dsa_req_t   aluReq;     // ALU request
  dsa_pkg::dsa_load_t  loadReq;    // From core model
  logic [2:0]          condSelect; // Condition mode
  logic                limitOn;    // Saturation enable
  logic [2:0]          readIdx;    // Readback index
  logic [39:0]         readData;   // Readback value
  dsa_pkg::dsa_flags_t flags;      // Flags seen
  logic                done;       // Op retired
  logic [39:0]         result;     // Last result
  int                  failures;   // Mismatch count
  int                  checked;    // Compare count
  int                  cycles;     // Timeout counter

  dsa_core_model core (.clock(clock), .loadReq(loadReq));
  dsa_alu dut (
    .clock(clock), .rst_n(rst_n), .aluReq(aluReq), .loadReq(loadReq),
    .condSelect(condSelect), .limitOnFlag(limitOn), .readIdx(readIdx),
    .readData_ff(readData), .flags_ff(flags), .done_ff(done),
    .result_ff(result));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the run needs under a hundred cycles
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles > 2000) begin
      failures++;
      stop_test();
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Pulse one request; returns once its results are visible
  task automatic alu(input dsa_pkg::dsa_op_t op,
                     input dsa_pkg::dsa_exec_t ex,
                     input logic [2:0] x, input logic [2:0] y,
                     input logic [2:0] d);
    @(posedge clock);
    #1;
    aluReq = '{1'b1, op, ex, x, y, d, 1'b0};
    @(posedge clock);
    #1;
    aluReq.valid = 1'b0;
  endtask

  task automatic rd(input logic [2:0] i, input logic [39:0] exp);
    readIdx = i;
    @(posedge clock);
    #1;
    check(readData, exp);
  endtask

  task automatic fl(input logic [4:0] exp);
    check({35'h0, flags}, {35'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_overflow;
    condSelect = dsa_pkg::CS_OVF;
    alu(dsa_pkg::SUM_OP, dsa_pkg::EXEC_ALWAYS, 3'h2, 3'h3, 3'h0);
    check(result, 40'h00_8000_0000);
    check({39'h0, done}, 40'h1);
    fl(5'b10011);
    alu(dsa_pkg::SUM_OP, dsa_pkg::EXEC_ALWAYS, 3'h2, 3'h3, 3'h4);
    rd(3'h4, 40'hFF_8000_0000);
  endtask

  task automatic t_conditional;
    alu(dsa_pkg::DIFF_OP, dsa_pkg::EXEC_IF_SET, 3'h3, 3'h3, 3'h0);
    check(result, 40'h00_0000_0000);
    fl(5'b10011);
  endtask

  // Compare must come before greater-type use of the flag
  task automatic t_compare_carry;
    condSelect = dsa_pkg::CS_GT;
    alu(dsa_pkg::COMPARE_OP, dsa_pkg::EXEC_ALWAYS, 3'h3, 3'h2, 3'h1);
    check({39'h0, done}, 40'h0);
    fl(5'b01000);
    alu(dsa_pkg::COMPARE_OP, dsa_pkg::EXEC_ALWAYS, 3'h2, 3'h3, 3'h1);
    fl(5'b10001);
    condSelect = dsa_pkg::CS_NEG;
    alu(dsa_pkg::COMPARE_OP, dsa_pkg::EXEC_ALWAYS, 3'h3, 3'h2, 3'h1);
    fl(5'b11000);
    condSelect = dsa_pkg::CS_ZERO;
    alu(dsa_pkg::SUM_CARRY_OP, dsa_pkg::EXEC_ALWAYS, 3'h5, 3'h3, 3'h0);
    check(result, 40'h00_0000_0001);
    fl(5'b10001);
    condSelect = dsa_pkg::CS_GE;
    alu(dsa_pkg::COMPARE_OP, dsa_pkg::EXEC_ALWAYS, 3'h3, 3'h3, 3'h1);
    fl(5'b10100);
  endtask

  task automatic t_integer;
    alu(dsa_pkg::INCREMENT_OP, dsa_pkg::EXEC_ALWAYS, 3'h6, 3'h0, 3'h0);
    check(result, 40'h00_1235_0000);
    alu(dsa_pkg::DECREMENT_OP, dsa_pkg::EXEC_ALWAYS, 3'h6, 3'h0, 3'h1);
    rd(3'h1, 40'h00_1233_0000);
  endtask

  task automatic t_logical;
    condSelect = dsa_pkg::CS_NEG;
    alu(dsa_pkg::OR_OP, dsa_pkg::EXEC_ALWAYS, 3'h7, 3'h6, 3'h0);
    check(result, 40'h00_F2F4_0000);
    fl(5'b11000);
    condSelect = dsa_pkg::CS_CARRY;
    alu(dsa_pkg::XOR_OP, dsa_pkg::EXEC_ALWAYS, 3'h7, 3'h7, 3'h0);
    fl(5'b00100);
    condSelect = dsa_pkg::CS_ZERO;
    alu(dsa_pkg::AND_OP, dsa_pkg::EXEC_ALWAYS, 3'h6, 3'h7, 3'h1);
    rd(3'h1, 40'h00_1030_0000);
    fl(5'b00000);
  endtask

  // Load into a source in the same line: the old value is summed
  task automatic t_same_line;
    fork
      core.load(3'h3, 40'h00_0000_0005);
      alu(dsa_pkg::SUM_OP, dsa_pkg::EXEC_ALWAYS, 3'h3, 3'h3, 3'h0);
    join
    check(result, 40'h00_0000_0002);
    rd(3'h3, 40'h00_0000_0005);
  endtask

  // One-source forms; reg4 reads as -2^31, reg3 holds 5
  task automatic t_one_source;
    condSelect = dsa_pkg::CS_ZERO;
    alu(dsa_pkg::ABSOLUTE_OP, dsa_pkg::EXEC_ALWAYS, 3'h4, 3'h0, 3'h0);
    check(result, 40'h00_8000_0000);
    alu(dsa_pkg::ABSOLUTE_OP, dsa_pkg::EXEC_ALWAYS, 3'h3, 3'h0, 3'h0);
    check(result, 40'h00_0000_0005);
    alu(dsa_pkg::NEGATE_OP, dsa_pkg::EXEC_ALWAYS, 3'h3, 3'h0, 3'h0);
    check(result, 40'hFF_FFFF_FFFB);
    alu(dsa_pkg::COPY_OP, dsa_pkg::EXEC_ALWAYS, 3'h6, 3'h0, 3'h0);
    check(result, 40'h00_1234_5678);
    alu(dsa_pkg::CLEAR_OP, dsa_pkg::EXEC_ALWAYS, 3'h6, 3'h6, 3'h1);
    rd(3'h1, 40'h00_0000_0000);
    fl(5'b10100);
  endtask

  // Unguarded destination clamps on base-range overflow
  task automatic t_saturate;
    limitOn = 1'b1;
    alu(dsa_pkg::SUM_OP, dsa_pkg::EXEC_ALWAYS, 3'h2, 3'h2, 3'h4);
    check(result, 40'h00_7FFF_FFFF);
    alu(dsa_pkg::SUM_OP, dsa_pkg::EXEC_ALWAYS, 3'h2, 3'h2, 3'h0);
    check(result, 40'h00_FFFF_FFFE);
    limitOn = 1'b0;
  endtask

  task automatic stop_test;
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    failures = 0;
    checked = 0;
    cycles = 0;
    condSelect = 3'h0;
    limitOn = 1'b0;
    readIdx = 3'h0;
    aluReq = '{1'b0, dsa_pkg::SUM_OP, dsa_pkg::EXEC_ALWAYS,
               3'h0, 3'h0, 3'h0, 1'b0};
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    core.load(3'h2, 40'h00_7FFF_FFFF);
    core.load(3'h3, 40'h00_0000_0001);
    core.load(3'h5, 40'h00_FFFF_FFFF);
    core.load(3'h6, 40'h00_1234_5678);
    core.load(3'h7, 40'h00_F0F0_1234);
    t_overflow();
    t_conditional();
    t_compare_carry();
    t_integer();
    t_logical();
    t_same_line();
    t_one_source();
    t_saturate();
    stop_test();
  end
endmodule
